/* rtl/bdls_pkg.sv */
package bdls_pkg;
	// ****************************************
	// Bus encodings
	// ****************************************
	localparam int unsigned DATA_W = 32;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_ERROR = 2'h1;
	localparam logic [1:0] RESP_RETRY = 2'h2;
	localparam logic [1:0] RESP_SPLIT = 2'h3;
	localparam logic [1:0] TRANS_IDLE = 2'h0;
	localparam logic [1:0] TRANS_BUSY = 2'h1;
	localparam logic [2:0] SIZE_BYTE = 3'h0;
	localparam logic [2:0] SIZE_HALF = 3'h1;
	localparam logic [2:0] SIZE_WORD = 3'h2;
	// ****************************************
	// Reset values, timing and storage depth
	// ****************************************
	localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;
	localparam logic [3:0] LANES_NONE = 4'h0;
	localparam int unsigned WAIT_STATES = 1;
	localparam int unsigned MEM_DEPTH = 16;

	typedef enum logic [1:0] {
		BDLS_IDLE = 2'b00,
		BDLS_WAIT = 2'b01,
		BDLS_ERR1 = 2'b10,
		BDLS_ERR2 = 2'b11
	} bdls_state_t;

	// Active byte lanes for size and offset; big_end picks the mirror table
	function automatic logic [3:0] lanes(input logic [2:0] size, input logic [1:0] off,
			input logic big_end);
		logic [3:0] le;
		le = 4'h0;
		case (size)
			SIZE_BYTE: le = 4'h1 << off;
			SIZE_HALF: le = off[1] ? 4'hC : 4'h3;
			default: le = 4'hF;
		endcase
		if (big_end) begin
			lanes = {le[0], le[1], le[2], le[3]};
		end else begin
			lanes = le;
		end
	endfunction

	// Misaligned for the given size
	function automatic logic misaligned(input logic [2:0] size, input logic [1:0] off);
		case (size)
			SIZE_BYTE: misaligned = 1'b0;
			SIZE_HALF: misaligned = off[0];
			SIZE_WORD: misaligned = |off;
			default: misaligned = 1'b1;
		endcase
	endfunction
endpackage

/* rtl/bdls_buf_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface bdls_buf_if;
	logic in_valid;
	logic in_ready;
	logic [31:0] in_data;
	logic [3:0] in_strb;
	logic [5:0] in_addr;
	logic out_valid;
	logic out_ready;
	logic [31:0] out_data;
	logic [3:0] out_strb;
	logic [5:0] out_addr;
	modport fill (output in_valid, in_data, in_strb, in_addr, input in_ready,
		input out_valid, out_data, out_strb, out_addr, output out_ready);
	modport buffer (input in_valid, in_data, in_strb, in_addr, output in_ready,
		output out_valid, out_data, out_strb, out_addr, input out_ready);
endinterface
`default_nettype wire

/* rtl/bdls_buf2.sv */
`timescale 1ns/1ps
`default_nettype none
module bdls_buf2 (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Buffer ports
	bdls_buf_if.buffer bus
);
	localparam int unsigned W = 32 + 4 + 6;
	logic [W-1:0] mem_reg [2];
	logic [W-1:0] mem_next [2];
	logic wptr_reg, wptr_next, rptr_reg, rptr_next;
	logic [1:0] cnt_reg, cnt_next;
	logic push, pop;

	assign bus.in_ready = (cnt_reg != 2'h2);
	assign bus.out_valid = (cnt_reg != 2'h0);
	assign {bus.out_data, bus.out_strb, bus.out_addr} = mem_reg[rptr_reg];
	assign push = bus.in_valid && bus.in_ready;
	assign pop = bus.out_valid && bus.out_ready;

	always_comb begin
		mem_next = mem_reg;
		wptr_next = wptr_reg;
		rptr_next = rptr_reg;
		cnt_next = cnt_reg;
		if (push) begin
			mem_next[wptr_reg] = {bus.in_data, bus.in_strb, bus.in_addr};
			wptr_next = ~wptr_reg;
		end
		if (pop) begin
			rptr_next = ~rptr_reg;
		end
		if (push && !pop) begin
			cnt_next = cnt_reg + 2'h1;
		end else if (pop && !push) begin
			cnt_next = cnt_reg - 2'h1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mem_reg[0] <= '0;
			mem_reg[1] <= '0;
			wptr_reg <= 1'b0;
			rptr_reg <= 1'b0;
			cnt_reg <= 2'h0;
		end else begin
			mem_reg <= mem_next;
			wptr_reg <= wptr_next;
			rptr_reg <= rptr_next;
			cnt_reg <= cnt_next;
		end
	end

	a_buf_no_over: assert property (@(posedge clk) disable iff (rst)
		cnt_reg == 2'h2 |-> !bus.in_ready)
		else $error("buffer accepts while full");
endmodule
`default_nettype wire

/* rtl/bdls_slave.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Separate one-way read and write buses
// - Write data taken from active lanes
// - Lanes recomputed per beat from address
// - One endianness shared by whole bus
// - Read data valid when ready high
// - Read drives only active lanes validly
// - Read data valid only on OKAY
// - Little-endian lane table
// - Big-endian lane table
// - Endianness static, caught at reset release
// - Bi-endian by configuration pin
// - Ready low stretches, high completes
// - Response codes OKAY and ERROR only; RETRY and SPLIT never driven
module bdls_slave #(
	parameter int unsigned DATA_W = bdls_pkg::DATA_W,
	parameter int unsigned WAITS = bdls_pkg::WAIT_STATES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Configuration strap
	input wire logic big_endian_pin,
	// Address and control
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready_in,
	// Data buses
	input wire logic [DATA_W-1:0] hwdata,
	output logic [DATA_W-1:0] hrdata,
	// Response
	output logic hready_out,
	output logic [1:0] hresp,
	// Drained write stream
	output logic wr_valid,
	input wire logic wr_ready,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	output logic [5:0] wr_addr
);
	// ****************************************
	// Endianness strap
	// ****************************************
	// Pin synchronised, then frozen once; never changes while running
	// Capture waits until the second stage holds the pin, not its reset value
	logic be_s1_reg, be_s2_reg, be_reg, be_done_reg;
	logic [1:0] be_v_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			be_s1_reg <= 1'b0;
			be_s2_reg <= 1'b0;
			be_reg <= 1'b0;
			be_done_reg <= 1'b0;
			be_v_reg <= 2'h0;
		end else begin
			be_s1_reg <= big_endian_pin;
			be_s2_reg <= be_s1_reg;
			be_v_reg <= {be_v_reg[0], 1'b1};
			if (!be_done_reg && be_v_reg[1]) begin
				be_reg <= be_s2_reg;
				be_done_reg <= 1'b1;
			end
		end
	end

	// ****************************************
	// Address phase capture
	// ****************************************
	bdls_pkg::bdls_state_t st_reg, st_next;
	logic [3:0] lanes_reg, lanes_next;
	logic wr_reg, wr_next;
	logic [5:0] addr_reg, addr_next;
	logic [3:0] wcnt_reg, wcnt_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	logic [31:0] mem_reg [bdls_pkg::MEM_DEPTH];
	logic [31:0] mem_next [bdls_pkg::MEM_DEPTH];
	logic start, bad, complete, ok_done;
	logic [31:0] word;

	// Keeps active lanes of a word, zeroes the rest
	function automatic logic [31:0] lane_pick(input logic [31:0] w, input logic [3:0] l);
		lane_pick = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			if (l[i]) begin
				lane_pick[i*8 +: 8] = w[i*8 +: 8];
			end
		end
	endfunction

	bdls_buf_if bif ();
	bdls_buf2 u_buf (
		.clk(clk),
		.rst(rst),
		.bus(bif.buffer)
	);

	assign start = hsel && hready_in && htrans[1];
	assign bad = bdls_pkg::misaligned(hsize, haddr[1:0]);
	// Buffer full stalls the data phase, so no word is lost
	assign complete = (st_reg == bdls_pkg::BDLS_WAIT) && (wcnt_reg == 4'h0)
		&& (!wr_reg || bif.in_ready);
	assign ok_done = complete;
	assign word = mem_reg[addr_reg[5:2]];

	always_comb begin
		st_next = st_reg;
		lanes_next = lanes_reg;
		wr_next = wr_reg;
		addr_next = addr_reg;
		wcnt_next = wcnt_reg;
		rdata_next = rdata_reg;
		mem_next = mem_reg;
		hready_out = 1'b1;
		hresp = bdls_pkg::RESP_OKAY;
		case (st_reg)
			bdls_pkg::BDLS_WAIT: begin
				hready_out = complete;
				if (wcnt_reg != 4'h0) begin
					wcnt_next = wcnt_reg - 4'h1;
				end
				// Reloaded while waiting so data stands in the ready cycle
				if (!complete && !wr_reg) begin
					rdata_next[31:0] = lane_pick(word, lanes_reg);
				end
				if (complete) begin
					st_next = bdls_pkg::BDLS_IDLE;
				end
			end
			bdls_pkg::BDLS_ERR1: begin
				hready_out = 1'b0;
				hresp = bdls_pkg::RESP_ERROR;
				st_next = bdls_pkg::BDLS_ERR2;
			end
			bdls_pkg::BDLS_ERR2: begin
				hresp = bdls_pkg::RESP_ERROR;
				st_next = bdls_pkg::BDLS_IDLE;
			end
			default: st_next = bdls_pkg::BDLS_IDLE;
		endcase
		// New address phase overlaps a completing data phase
		if (hready_out && start && st_next == bdls_pkg::BDLS_IDLE) begin
			st_next = bad ? bdls_pkg::BDLS_ERR1 : bdls_pkg::BDLS_WAIT;
			lanes_next = bdls_pkg::lanes(hsize, haddr[1:0], be_reg);
			wr_next = hwrite;
			addr_next = haddr[5:0];
			wcnt_next = 4'(WAITS);
			// Limitation: a write still in the buffer is not seen here
			if (!bad && !hwrite) begin
				rdata_next[31:0] = lane_pick(mem_reg[haddr[5:2]], lanes_next);
			end
		end
		// Read-back mirrors stored writes
		if (bif.out_valid && !bif.out_ready) begin
			mem_next = mem_reg;
		end
		for (int i = 0; i < 4; i++) begin
			if (bif.out_valid && bif.out_ready && bif.out_strb[i]) begin
				mem_next[bif.out_addr[5:2]][i*8 +: 8] = bif.out_data[i*8 +: 8];
			end
		end
	end

	// Write data sampled only in the completing cycle
	assign bif.in_valid = complete && wr_reg;
	assign bif.in_strb = lanes_reg;
	assign bif.in_addr = addr_reg;
	always_comb begin
		bif.in_data = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			if (lanes_reg[i]) begin
				bif.in_data[i*8 +: 8] = hwdata[i*8 +: 8];
			end
		end
	end
	// Stream out: buffer drains to the user and also to local storage
	assign bif.out_ready = wr_ready;
	assign wr_valid = bif.out_valid;
	assign wr_data = bif.out_data;
	assign wr_strb = bif.out_strb;
	assign wr_addr = bif.out_addr;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg <= bdls_pkg::BDLS_IDLE;
			lanes_reg <= bdls_pkg::LANES_NONE;
			wr_reg <= 1'b0;
			addr_reg <= 6'h00;
			wcnt_reg <= 4'h0;
			rdata_reg <= bdls_pkg::RDATA_RESET;
			for (int i = 0; i < bdls_pkg::MEM_DEPTH; i++) begin
				mem_reg[i] <= 32'h0000_0000;
			end
		end else begin
			st_reg <= st_next;
			lanes_reg <= lanes_next;
			wr_reg <= wr_next;
			addr_reg <= addr_next;
			wcnt_reg <= wcnt_next;
			rdata_reg <= rdata_next;
			mem_reg <= mem_next;
		end
	end

	// Separate output bus, no tristate; stands while ready high
	assign hrdata = rdata_reg;

	// ****************************************
	// Checks
	// ****************************************
	sequence s_err_first;
		!hready_out && hresp == bdls_pkg::RESP_ERROR;
	endsequence
	sequence s_err_last;
		hready_out && hresp == bdls_pkg::RESP_ERROR;
	endsequence

	a_err_two_cycle: assert property (@(posedge clk) disable iff (rst)
		s_err_first |=> s_err_last)
		else $error("error response not two cycles");
	a_misalign_errors: assert property (@(posedge clk) disable iff (rst)
		(hready_out && start && bad) |=> s_err_first)
		else $error("misaligned access not refused");
	a_wait_stretch: assert property (@(posedge clk) disable iff (rst)
		(hready_out && start && !bad && WAITS > 0) |=> !hready_out)
		else $error("no wait state inserted");
	a_wait_okay: assert property (@(posedge clk) disable iff (rst)
		(st_reg == bdls_pkg::BDLS_WAIT) |-> hresp == bdls_pkg::RESP_OKAY)
		else $error("wait not OKAY");
	a_endian_frozen: assert property (@(posedge clk) disable iff (rst)
		be_done_reg && $past(be_done_reg) |-> $stable(be_reg))
		else $error("endianness changed");
	a_strobe_lanes: assert property (@(posedge clk) disable iff (rst)
		bif.in_valid |-> bif.in_strb != 4'h0 && hready_out)
		else $error("write stored outside completion");
	a_read_lanes: assert property (@(posedge clk) disable iff (rst)
		(complete && !wr_reg) |->
		(hrdata[31:0] & ~lane_pick(32'hFFFF_FFFF, lanes_reg)) == 32'h0000_0000)
		else $error("read data on inactive lane");
	a_word_lanes: assert property (@(posedge clk) disable iff (rst)
		(hready_out && start && !bad && hsize == bdls_pkg::SIZE_WORD) |=> lanes_reg == 4'hF)
		else $error("word not all lanes");
endmodule
`default_nettype wire

/* sim/bdls_mst.sv */
`timescale 1ns/1ps
`default_nettype none
module bdls_mst (
	// Clock and response
	input wire logic clk,
	input wire logic hready,
	input wire logic [1:0] hresp,
	input wire logic [31:0] hrdata,
	// Address, control and write data
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = bdls_pkg::TRANS_IDLE;
		hwrite = 1'b0;
		hsize = 3'h0;
		hwdata = 32'h0;
	end

	// ****
	// Ready wait
	// ****
	// Ready is read at the falling edge; it holds until the next rising edge
	task automatic rdy();
		int n;
		n = 0;
		while (hready !== 1'b1 && n < 64) begin
			n++;
			@(negedge clk);
		end
	endtask

	// ****
	// One transfer
	// ****
	task automatic xfer(input logic w, input logic [2:0] sz, input logic [31:0] a,
			input logic [31:0] d, output logic [1:0] r, output logic [31:0] rd);
		@(negedge clk);
		rdy();
		hsel = 1'b1;
		htrans = 2'h2;
		haddr = a;
		hwrite = w;
		hsize = sz;
		@(negedge clk);
		hsel = 1'b0;
		htrans = bdls_pkg::TRANS_IDLE;
		haddr = ~a;
		hwdata = w ? d : ~hwdata; // Idle lanes carry junk
		rdy(); // Data held until ready
		r = hresp;
		rd = hrdata;
		@(negedge clk);
		hwdata = ~hwdata;
	endtask
endmodule
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 1'b0;
	logic rst, big_endian_pin, hsel, hwrite, hready_out, wr_valid, wr_ready;
	logic [31:0] haddr, hwdata, hrdata, wr_data, rd, last_data;
	logic [1:0] htrans, hresp, r;
	logic [2:0] hsize;
	logic [3:0] wr_strb, last_strb;
	logic [5:0] wr_addr;
	int num_errors = 0;
	int checks = 0;
	int pops = 0;

	always #5 clk = ~clk;

	bdls_slave dut (.clk(clk), .rst(rst), .big_endian_pin(big_endian_pin), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hready_in(hready_out), .hwdata(hwdata), .hrdata(hrdata), .hready_out(hready_out),
		.hresp(hresp), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
		.wr_strb(wr_strb), .wr_addr(wr_addr));
	bdls_mst mst (.clk(clk), .hready(hready_out), .hresp(hresp), .hrdata(hrdata),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata));

	always @(negedge clk) begin
		if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
			last_strb <= wr_strb;
			last_data <= wr_data;
			pops <= pops + 1;
		end
	end

	// ****
	// Helpers
	// ****
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic conclude();
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Same endianness as the strap
	function automatic logic [3:0] lanes_exp(input logic [2:0] s, input logic [1:0] o,
			input logic be);
		if (s == bdls_pkg::SIZE_BYTE) return be ? 4'h8 >> o : 4'h1 << o;
		if (s == bdls_pkg::SIZE_HALF) return (o[1] ^ be) ? 4'hC : 4'h3;
		return 4'hF;
	endfunction

	task automatic do_reset(input logic be);
		@(negedge clk);
		rst = 1'b1;
		big_endian_pin = be;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
	endtask

	// ****
	// Scenarios
	// ****
	task automatic sc_lanes(input logic be);
		logic [31:0] m, ew, d;
		logic [3:0] l;
		do_reset(be);
		ew = 32'h0;
		mst.xfer(1'b1, bdls_pkg::SIZE_WORD, 32'h8, ew, r, rd);
		for (int s = 0; s < 3; s++) begin
			for (int o = 0; o < 4; o += 1 << s) begin
				l = lanes_exp(3'(s), 2'(o), be);
				m = {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
				d = 32'h8C6B_4A29 + 32'(o + 4 * s);
				mst.xfer(1'b1, 3'(s), 32'h8 + 32'(o), d, r, rd);
				check(32'(r), 32'(bdls_pkg::RESP_OKAY), "write resp");
				ew = (ew & ~m) | (d & m);
				mst.xfer(1'b0, 3'(s), 32'h8 + 32'(o), 32'h0, r, rd);
				check(rd, ew & m, "narrow read");
				check(32'(last_strb), 32'(l), "lanes");
				check(last_data & m, d & m, "write lanes");
				mst.xfer(1'b0, bdls_pkg::SIZE_WORD, 32'h8, 32'h0, r, rd);
				check(rd, ew, "stored word");
			end
		end
	endtask

	task automatic sc_static();
		big_endian_pin = 1'b0;
		repeat (4) @(negedge clk);
		mst.xfer(1'b1, bdls_pkg::SIZE_WORD, 32'h4, 32'h1234_5678, r, rd);
		mst.xfer(1'b1, bdls_pkg::SIZE_BYTE, 32'h4, 32'h0000_00FF, r, rd);
		mst.xfer(1'b1, bdls_pkg::SIZE_BYTE, 32'h4, 32'hFFFF_FFFF, r, rd);
		mst.xfer(1'b0, bdls_pkg::SIZE_WORD, 32'h4, 32'h0, r, rd);
		check(rd, 32'hFF34_5678, "strap frozen");
	endtask

	task automatic sc_error();
		logic [2:0] sz [3] = '{3'h1, 3'h2, 3'h3};
		logic [31:0] ad [3] = '{32'h9, 32'hA, 32'h8};
		int p;
		for (int i = 0; i < 3; i++) begin
			p = pops;
			mst.xfer(1'b1, sz[i], ad[i], 32'h0, r, rd);
			check(32'(r), 32'(bdls_pkg::RESP_ERROR), "write error");
			mst.xfer(1'b0, sz[i], ad[i], 32'h0, r, rd);
			check(32'(r), 32'(bdls_pkg::RESP_ERROR), "read error");
			check(rd, 32'hFF34_5678, "read kept");
			check(32'(pops - p), 32'h0, "no store");
		end
	endtask

	task automatic sc_stall();
		wr_ready = 1'b0;
		for (int i = 0; i < 2; i++)
			mst.xfer(1'b1, bdls_pkg::SIZE_WORD, 32'h20 + 32'(4 * i), 32'hC0DE_0000 + 32'(i), r, rd);
		fork
			mst.xfer(1'b1, bdls_pkg::SIZE_WORD, 32'h28, 32'hC0DE_0002, r, rd);
			begin
				repeat (6) @(negedge clk);
				check(32'(hready_out), 32'h0, "stall");
				check(32'(wr_valid), 32'h1, "buffered");
				wr_ready = 1'b1;
			end
		join
		for (int i = 0; i < 3; i++) begin
			mst.xfer(1'b0, bdls_pkg::SIZE_WORD, 32'h20 + 32'(4 * i), 32'h0, r, rd);
			check(rd, 32'hC0DE_0000 + 32'(i), "no loss");
		end
	endtask

	initial begin
		rst = 1'b1;
		big_endian_pin = 1'b0;
		wr_ready = 1'b1;
		sc_lanes(1'b0);
		sc_lanes(1'b1);
		sc_static();
		sc_error();
		sc_stall();
		conclude();
	end

	// Whole run needs a few hundred cycles; this is far beyond
	initial begin
		#100000;
		num_errors++;
		conclude();
	end
endmodule
`default_nettype wire
